// ===== rtl/sdc_params.svh
// Constants for the supply detector configuration block: commands, fields, resets, timing
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// Command codes
`define SDC_PAGE_CMD        8'h00
`define SDC_CFG_CMD         8'hd2

// Page limits
`define SDC_LAST_PAGE       16'h0010
`define SDC_LAST_HIGH_PAGE  5'h03
`define SDC_PAGE_W          5

// Field positions inside the configuration word
`define SDC_SPAN_MSB        15
`define SDC_SPAN_LSB        13
`define SDC_DIFF_BIT        12
`define SDC_UNDER_W_MSB     11
`define SDC_UNDER_W_LSB     8
`define SDC_UNDER_EN_BIT    6
`define SDC_OVER_W_MSB      5
`define SDC_OVER_W_LSB      2
`define SDC_OVER_EN_BIT     0

// Bit 12 is read-only zero in the high-range layout
`define SDC_HIGH_WR_MASK    16'hefff
`define SDC_CFG_RESET       16'h0000

// Span codes at which an input is first connected, and the reserved code
`define SDC_HIGH_SPAN_MIN   3'h2
`define SDC_LOW_SPAN_MIN    3'h3
`define SDC_SPAN_RSVD       3'h7

// Timing, in ns
`define SDC_CLK_NS          10
`define SDC_SAMPLE_SLACK_NS 400
`define SDC_FLT_2US_NS      2000
`define SDC_FLT_4US_NS      4000
`define SDC_FLT_5US_NS      5000
`define SDC_FLT_6US_NS      6000
`define SDC_FLT_7US5_NS     7500
`define SDC_FLT_8US_NS      8000
`define SDC_FLT_10US_NS     10000
`define SDC_FLT_20US_NS     20000
`define SDC_FLT_40US_NS     40000
`define SDC_FLT_50US_NS     50000
`define SDC_FLT_60US_NS     60000
`define SDC_FLT_75US_NS     75000
`define SDC_FLT_80US_NS     80000
`define SDC_FLT_100US_NS    100000

`endif

// ===== rtl/sdc_pkg.sv
// Types shared by the supply detector configuration block
package sdc_pkg;

    // One host command: page select or configuration access
    typedef struct packed {
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } sdc_cmd_type;

    // Answer to one command
    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } sdc_rsp_type;

    // Configuration word, common to both layouts (diff_en is zero on high-range pages)
    typedef struct packed {
        logic [2:0] span;
        logic       diff_en;
        logic [3:0] under_width;
        logic       rsv7;
        logic       under_en;
        logic [3:0] over_width;
        logic       rsv1;
        logic       over_en;
    } sdc_cfg_type;

endpackage

// ===== rtl/sdc_cfg_mem.sv
// Per-channel configuration store with a registered read port and a parallel view
`timescale 1ns/100ps
`default_nettype none
`include "sdc_params.svh"

module sdc_cfg_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 17,
    parameter int AW    = 5
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic                   wr_en,
    input  wire logic [AW-1:0]          wr_addr,
    input  wire logic [WIDTH-1:0]       wr_data,
    input  wire logic                   rd_en,
    input  wire logic [AW-1:0]          rd_addr,
    output var  logic [WIDTH-1:0]       rd_data,
    output var  logic [DEPTH*WIDTH-1:0] all_words
);

    logic [WIDTH-1:0] word_r [DEPTH];

    // Words are flops, not RAM: every detector filter needs its own word at once
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                word_r[i] <= WIDTH'(`SDC_CFG_RESET);
            end
        end else if (wr_en) begin
            word_r[wr_addr] <= wr_data;
        end
    end

    // Read data is held until the next read
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= word_r[rd_addr];
        end
    end

    // Flat view for the filters
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            all_words[i*WIDTH +: WIDTH] = word_r[i];
        end
    end

endmodule // sdc_cfg_mem

`default_nettype wire

// ===== rtl/sdc_top.sv
// Supply detector configuration: page select, per-channel config word and glitch filters
//
// Notes on behaviour
// - Current page picks layout: pages 0-3 high-range, pages 4-16 low-range.
// - Low-range bits 15:13 pick span; codes 000-010 disconnect, 111 reserved.
// - Low-range bit 12 enables differential mode; ignored on even-numbered inputs.
// - Low-range bits 11:8 give undervoltage filter width, 2 to 100 us.
// - Pulses shorter than the filter width are dropped; sampling adds under 400 ns.
// - Low-range bit 6 enables the undervoltage comparator.
// - Low-range bits 5:2 give overvoltage filter width, same coding.
// - Low-range bit 0 enables the overvoltage comparator.
// - High-range bit 0 enables the overvoltage comparator.
// - High-range bits 15:13 pick span; 000-001 disconnect, 111 reserved.
// - High-range bits 11:8 give undervoltage filter width, same coding.
// - High-range bit 6 enables the undervoltage comparator.
// - High-range bits 5:2 give overvoltage filter width, same coding.
`timescale 1ns/100ps
`default_nettype none
`include "sdc_params.svh"

module sdc_top #(
    parameter int          NUM_CH        = 17,
    parameter int          NUM_HIGH      = 4,
    parameter int          CNT_W         = 14,
    parameter int unsigned FLT_40US_CYC  = `SDC_FLT_40US_NS / `SDC_CLK_NS,
    parameter int unsigned FLT_50US_CYC  = `SDC_FLT_50US_NS / `SDC_CLK_NS,
    parameter int unsigned FLT_60US_CYC  = `SDC_FLT_60US_NS / `SDC_CLK_NS,
    parameter int unsigned FLT_75US_CYC  = `SDC_FLT_75US_NS / `SDC_CLK_NS,
    parameter int unsigned FLT_80US_CYC  = `SDC_FLT_80US_NS / `SDC_CLK_NS,
    parameter int unsigned FLT_100US_CYC = `SDC_FLT_100US_NS / `SDC_CLK_NS
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic                   cmd_valid,
    input  wire sdc_pkg::sdc_cmd_type   cmd,
    output var  logic                   rsp_valid,
    output var  sdc_pkg::sdc_rsp_type   rsp,
    output var  logic [`SDC_PAGE_W-1:0] cur_page,
    input  wire logic [NUM_CH-1:0]      under_cmp,
    input  wire logic [NUM_CH-1:0]      over_cmp,
    output var  logic [NUM_CH-1:0]      under_fault,
    output var  logic [NUM_CH-1:0]      over_fault,
    output var  logic [NUM_CH*3-1:0]    chan_span_sel,
    output var  logic [NUM_CH-1:0]      chan_diff_en
);

    localparam int PW = `SDC_PAGE_W;
    localparam int DW = 16;

    // Short filter widths fit well below the parameter threshold
    localparam logic [CNT_W-1:0] F2   = CNT_W'(`SDC_FLT_2US_NS / `SDC_CLK_NS);
    localparam logic [CNT_W-1:0] F4   = CNT_W'(`SDC_FLT_4US_NS / `SDC_CLK_NS);
    localparam logic [CNT_W-1:0] F5   = CNT_W'(`SDC_FLT_5US_NS / `SDC_CLK_NS);
    localparam logic [CNT_W-1:0] F6   = CNT_W'(`SDC_FLT_6US_NS / `SDC_CLK_NS);
    localparam logic [CNT_W-1:0] F7H  = CNT_W'(`SDC_FLT_7US5_NS / `SDC_CLK_NS);
    localparam logic [CNT_W-1:0] F8   = CNT_W'(`SDC_FLT_8US_NS / `SDC_CLK_NS);
    localparam logic [CNT_W-1:0] F10  = CNT_W'(`SDC_FLT_10US_NS / `SDC_CLK_NS);
    localparam logic [CNT_W-1:0] F20  = CNT_W'(`SDC_FLT_20US_NS / `SDC_CLK_NS);
    localparam logic [CNT_W-1:0] F40  = CNT_W'(FLT_40US_CYC);
    localparam logic [CNT_W-1:0] F50  = CNT_W'(FLT_50US_CYC);
    localparam logic [CNT_W-1:0] F60  = CNT_W'(FLT_60US_CYC);
    localparam logic [CNT_W-1:0] F75  = CNT_W'(FLT_75US_CYC);
    localparam logic [CNT_W-1:0] F80  = CNT_W'(FLT_80US_CYC);
    localparam logic [CNT_W-1:0] F100 = CNT_W'(FLT_100US_CYC);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    // Filter code to cycles; reserved codes 0000 and 0001 fall back to the shortest width
    function automatic logic [CNT_W-1:0] filter_cycles(input logic [3:0] code);
        case (code)
            4'h2: filter_cycles = F2;
            4'h3: filter_cycles = F4;
            4'h4: filter_cycles = F5;
            4'h5: filter_cycles = F6;
            4'h6: filter_cycles = F7H;
            4'h7: filter_cycles = F8;
            4'h8: filter_cycles = F10;
            4'h9: filter_cycles = F20;
            4'ha: filter_cycles = F40;
            4'hb: filter_cycles = F50;
            4'hc: filter_cycles = F60;
            4'hd: filter_cycles = F75;
            4'he: filter_cycles = F80;
            4'hf: filter_cycles = F100;
            default: filter_cycles = F2;
        endcase
    endfunction

    // Span code carries a connected input; the connected range starts lower on high inputs
    function automatic logic span_live(input logic [2:0] span, input logic high);
        span_live = (span != `SDC_SPAN_RSVD) &&
                    (span >= (high ? `SDC_HIGH_SPAN_MIN : `SDC_LOW_SPAN_MIN));
    endfunction

    // Saturating step of a filter counter while the condition holds, restart otherwise
    function automatic logic [CNT_W-1:0] count_step(input logic act, input logic [CNT_W-1:0] c);
        count_step = !act ? '0 : ((c == CNT_MAX) ? c : c + CNT_W'(1));
    endfunction

    logic [PW-1:0]        page_r;
    logic                 s1_valid_r;
    logic                 s1_ack_r;
    logic                 s1_cfg_rd_r;
    logic [DW-1:0]        s1_page_data_r;
    logic                 rsp_valid_r;
    sdc_pkg::sdc_rsp_type rsp_r;
    logic [DW-1:0]        mem_rdata;
    logic [NUM_CH*DW-1:0] all_words;
    logic [NUM_CH-1:0]    under_q_r;
    logic [NUM_CH-1:0]    over_q_r;

    // Command decode
    wire cmd_is_page = cmd.code == `SDC_PAGE_CMD;
    wire cmd_is_cfg  = cmd.code == `SDC_CFG_CMD;
    wire page_in_rng = cmd.wdata <= `SDC_LAST_PAGE;
    wire page_wr     = cmd_valid && cmd.write && cmd_is_page && page_in_rng;
    wire page_rd     = cmd_valid && !cmd.write && cmd_is_page;
    wire cfg_wr      = cmd_valid && cmd.write && cmd_is_cfg;
    wire cfg_rd      = cmd_valid && !cmd.write && cmd_is_cfg;
    wire cmd_ack     = page_wr || page_rd || cfg_wr || cfg_rd;

    // Layout follows the current page; high layout keeps bit 12 at zero
    wire           cur_high = page_r <= `SDC_LAST_HIGH_PAGE;
    wire [DW-1:0]  wr_word  = cur_high ? (cmd.wdata & `SDC_HIGH_WR_MASK) : cmd.wdata;

    // Page register; an out-of-range page is refused and the old page kept
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            page_r <= '0;
        end else if (page_wr) begin
            page_r <= cmd.wdata[PW-1:0];
        end
    end

    sdc_cfg_mem #(
        .WIDTH (DW),
        .DEPTH (NUM_CH),
        .AW    (PW)
    ) u_cfg_mem (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .wr_en     (cfg_wr),
        .wr_addr   (page_r),
        .wr_data   (wr_word),
        .rd_en     (cfg_rd),
        .rd_addr   (page_r),
        .rd_data   (mem_rdata),
        .all_words (all_words)
    );

    // First answer stage waits for the memory's registered read
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s1_valid_r     <= 1'b0;
            s1_ack_r       <= 1'b0;
            s1_cfg_rd_r    <= 1'b0;
            s1_page_data_r <= '0;
        end else begin
            s1_valid_r     <= cmd_valid;
            s1_ack_r       <= cmd_ack;
            s1_cfg_rd_r    <= cfg_rd;
            s1_page_data_r <= page_rd ? DW'(page_r) : '0;
        end
    end

    // Answer is registered so the host sees clean data, at the cost of one more cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rsp_valid_r <= 1'b0;
            rsp_r       <= '0;
        end else begin
            rsp_valid_r <= s1_valid_r;
            rsp_r.ack   <= s1_ack_r;
            rsp_r.rdata <= s1_cfg_rd_r ? mem_rdata : s1_page_data_r;
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp       = rsp_r;
    assign cur_page  = page_r;

    // Comparator sample stage, one cycle of the allowed sampling slack
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            under_q_r <= '0;
            over_q_r  <= '0;
        end else begin
            under_q_r <= under_cmp;
            over_q_r  <= over_cmp;
        end
    end

    // Per-channel decode and glitch filters
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        localparam bit IS_HIGH = ch < NUM_HIGH;
        // Low inputs count from one; differential works only on odd-numbered ones
        localparam bit DIFF_OK = !IS_HIGH && (((ch - NUM_HIGH + 1) % 2) == 1);

        sdc_pkg::sdc_cfg_type cfg;
        logic [CNT_W-1:0]     under_cnt_r;
        logic [CNT_W-1:0]     over_cnt_r;
        logic                 under_fault_r;
        logic                 over_fault_r;

        assign cfg = all_words[ch*DW +: DW];

        wire             live      = span_live(cfg.span, IS_HIGH);
        wire             under_act = under_q_r[ch] && cfg.under_en && live;
        wire             over_act  = over_q_r[ch] && cfg.over_en && live;
        wire [CNT_W-1:0] under_lim = filter_cycles(cfg.under_width);
        wire [CNT_W-1:0] over_lim  = filter_cycles(cfg.over_width);
        wire [CNT_W-1:0] under_nxt = count_step(under_act, under_cnt_r);
        wire [CNT_W-1:0] over_nxt  = count_step(over_act, over_cnt_r);

        // Fault only once the condition has held for the whole width
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                under_cnt_r   <= '0;
                over_cnt_r    <= '0;
                under_fault_r <= 1'b0;
                over_fault_r  <= 1'b0;
            end else begin
                under_cnt_r   <= under_nxt;
                over_cnt_r    <= over_nxt;
                under_fault_r <= under_act && (under_nxt >= under_lim);
                over_fault_r  <= over_act && (over_nxt >= over_lim);
            end
        end

        assign under_fault[ch]          = under_fault_r;
        assign over_fault[ch]           = over_fault_r;
        assign chan_span_sel[ch*3 +: 3] = cfg.span;
        assign chan_diff_en[ch]         = DIFF_OK && cfg.diff_en;
    end

endmodule // sdc_top

`default_nettype wire

// ===== test/sdc_top_properties.sv
// Port checker for the supply detector configuration block
`timescale 1ns/100ps
`default_nettype none

module sdc_top_chk #(
    parameter int NUM_CH = 17
) (
    input wire logic                 ref_clk,
    input wire logic                 rstn,
    input wire logic                 cmd_valid,
    input wire sdc_pkg::sdc_cmd_type cmd,
    input wire logic                 rsp_valid,
    input wire sdc_pkg::sdc_rsp_type rsp,
    input wire logic [4:0]           cur_page,
    input wire logic [NUM_CH-1:0]    under_cmp,
    input wire logic [NUM_CH-1:0]    over_cmp,
    input wire logic [NUM_CH-1:0]    under_fault,
    input wire logic [NUM_CH-1:0]    over_fault,
    input wire logic [NUM_CH-1:0]    chan_diff_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Command classes, named once so the answer checks stay short
    sequence s_cfg;
        cmd_valid && cmd.code == 8'hd2;
    endsequence
    sequence s_bad_page;
        cmd_valid && cmd.write && cmd.code == 8'h00 && cmd.wdata > 16'h0010;
    endsequence
    sequence s_good_page;
        cmd_valid && cmd.write && cmd.code == 8'h00 && cmd.wdata <= 16'h0010;
    endsequence

    chk_answer_latency: assert property (cmd_valid |-> ##2 rsp_valid)
        else $error("answer missing two cycles after command");
    chk_no_stray_answer: assert property (rsp_valid |-> $past(cmd_valid, 2))
        else $error("answer without command");
    chk_page_take: assert property (s_good_page |=> cur_page == $past(cmd.wdata[4:0]))
        else $error("page not taken");
    chk_page_refused: assert property (s_bad_page |=> $stable(cur_page) ##1 !rsp.ack)
        else $error("page beyond 16 accepted");
    chk_cfg_ack: assert property (s_cfg |-> ##2 rsp_valid && rsp.ack)
        else $error("config access not acknowledged");
    chk_unknown_nak: assert property (cmd_valid && cmd.code != 8'h00 && cmd.code != 8'hd2
        |-> ##2 !rsp.ack && rsp.rdata == 16'h0000)
        else $error("unknown code acknowledged");
    chk_diff_gate: assert property ((chan_diff_en & NUM_CH'(17'h0aaaf)) == '0)
        else $error("differential enable on high or even input");
    chk_under_settle: assert property ((under_fault & ~$past(under_cmp, 2)) == '0)
        else $error("undervoltage fault without held comparator");
    chk_over_settle: assert property ((over_fault & ~$past(over_cmp, 2)) == '0)
        else $error("overvoltage fault without held comparator");
    chk_short_pulse: assert property (((under_fault & ~$past(under_fault))
        & ~$past(under_cmp, 10)) == '0)
        else $error("undervoltage fault after short pulse");
endmodule // sdc_top_chk

bind sdc_top sdc_top_chk #(.NUM_CH(NUM_CH)) u_chk (.ref_clk(ref_clk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .cur_page(cur_page),
    .under_cmp(under_cmp), .over_cmp(over_cmp), .under_fault(under_fault),
    .over_fault(over_fault), .chan_diff_en(chan_diff_en));
`default_nettype wire

// ===== test/sdc_host.sv
// Host model that issues page and configuration commands
`timescale 1ns/100ps
`default_nettype none

module sdc_host (
    input  wire logic                 ref_clk,
    output var  logic                 cmd_valid,
    output var  sdc_pkg::sdc_cmd_type cmd,
    input  wire logic                 rsp_valid,
    input  wire sdc_pkg::sdc_rsp_type rsp
);
    // Idle until the first command
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end

    // One command, then a bounded wait for its answer
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output sdc_pkg::sdc_rsp_type r);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd = {w, c, d};
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        // Fields turn to junk after the take, so a late sample is caught
        cmd = {~w, ~c, ~d};
        while (rsp_valid !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        // No answer in time: unknown data makes the caller's compare fail
        if (rsp_valid === 1'b1) begin
            r = rsp;
        end else begin
            r = 'x;
        end
    endtask
endmodule // sdc_host
`default_nettype wire

// ===== test/tb.sv
// Self-checking testbench for the supply detector configuration block
`timescale 1ns/100ps
`default_nettype none
`include "sdc_params.svh"

module tb;
    logic                 ref_clk;
    logic                 rstn;
    logic                 cmd_valid;
    logic                 rsp_valid;
    sdc_pkg::sdc_cmd_type cmd;
    sdc_pkg::sdc_rsp_type rsp;
    sdc_pkg::sdc_rsp_type r;
    logic [4:0]           cur_page;
    logic [16:0]          under_cmp;
    logic [16:0]          over_cmp;
    logic [16:0]          under_fault;
    logic [16:0]          over_fault;
    logic [16:0]          chan_diff_en;
    logic [50:0]          chan_span_sel;
    int                   num_errors = 0;
    int                   check_count = 0;

    // Filter counts for 40 to 80 us shortened so the run stays brief; 100 us keeps its full count
    sdc_top #(.FLT_40US_CYC(40), .FLT_50US_CYC(50), .FLT_60US_CYC(60), .FLT_75US_CYC(75),
        .FLT_80US_CYC(80)) DUT (.ref_clk(ref_clk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .cur_page(cur_page),
        .under_cmp(under_cmp), .over_cmp(over_cmp), .under_fault(under_fault),
        .over_fault(over_fault), .chan_span_sel(chan_span_sel), .chan_diff_en(chan_diff_en));
    sdc_host HOST (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid),
        .rsp(rsp));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One access, answer compared as ack and read data together
    task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                       input logic [16:0] exp);
        HOST.xfer(w, c, d, r);
        chk("answer", exp, {r.ack, r.rdata});
    endtask

    task automatic pg(input logic [15:0] p);
        HOST.xfer(1'b1, `SDC_PAGE_CMD, p, r);
        chk("page ack", 17'h00001, {16'h0000, r.ack});
        chk("page", {12'h000, p[4:0]}, {12'h000, cur_page});
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A hang counts as a mismatch
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end

    initial begin
        rstn = 1'b0;
        under_cmp = '0;
        over_cmp = '0;
        step(8);
        rstn = 1'b1;
        acc(1'b0, `SDC_CFG_CMD, 16'h0000, 17'h10000);
        acc(1'b0, `SDC_PAGE_CMD, 16'h0000, 17'h10000);
        acc(1'b1, `SDC_PAGE_CMD, 16'h0011, 17'h00000);
        chk("page kept", 17'h00000, {12'h000, cur_page});
        acc(1'b0, 8'h5a, 16'h0000, 17'h00000);
        // Every page: span 011 with the differential bit set
        for (int p = 0; p <= 16; p++) begin
            pg(p[15:0]);
            acc(1'b1, `SDC_CFG_CMD, 16'h7000, 17'h10000);
            acc(1'b0, `SDC_CFG_CMD, 16'h0000, {1'b1, p < 4 ? 16'h6000 : 16'h7000});
            chk("diff", {16'h0000, p >= 4 && p % 2 == 0}, {16'h0000, chan_diff_en[p]});
            chk("span", 17'h00003, {14'h0000, chan_span_sel[p*3 +: 3]});
        end
        pg(16'h0000);
        acc(1'b1, `SDC_CFG_CMD, 16'hffff, 17'h10000);
        acc(1'b0, `SDC_CFG_CMD, 16'h0000, 17'h1efff);
        pg(16'h0004);
        acc(1'b0, `SDC_PAGE_CMD, 16'h0000, 17'h10004);
        acc(1'b1, `SDC_CFG_CMD, 16'h6a40, 17'h10000);
        // Channel 0 has the reserved span; channel 4 over comparator is off
        under_cmp = 17'h00011;
        over_cmp = 17'h00011;
        step(39);
        under_cmp[4] = 1'b0;
        step(5);
        chk("short pulse", 17'h00000, under_fault);
        under_cmp[4] = 1'b1;
        step(40);
        chk("under early", 17'h00000, under_fault);
        step(1);
        chk("under fault", 17'h00010, under_fault);
        chk("over off", 17'h00000, over_fault);
        over_cmp[4] = 1'b0;
        acc(1'b1, `SDC_CFG_CMD, 16'h6a49, 17'h10000);
        over_cmp[4] = 1'b1;
        step(200);
        chk("over early", 17'h00000, over_fault);
        step(1);
        chk("over fault", 17'h00010, over_fault);
        under_cmp[4] = 1'b0;
        step(2);
        chk("under drop", 17'h00000, under_fault);
        acc(1'b1, `SDC_CFG_CMD, 16'h4a49, 17'h10000);
        step(2);
        chk("disconnected", 17'h00000, over_fault);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
